//--- core/fsr_cfg.svh
/*
 * Constants of the suspend and resume sequencer: instruction codes,
 * discovery table words, timing figures and bus offsets.
 * Assumes a 250 MHz core clock.
 */
`ifndef FSR_CFG_SVH
`define FSR_CFG_SVH

`define FSR_CLK_MHZ 250
`define FSR_OP_SUSPEND 8'h75
`define FSR_OP_RESUME 8'h7a
`define FSR_OP_ERASE 8'h20
`define FSR_OP_PROGRAM 8'h02
// Latency field: unit 8 us (code 2'b10), count 5'b00100, so (4+1)*8 = 40 us.
`define FSR_LAT_UNIT 2'h2
`define FSR_LAT_COUNT 5'h04
`define FSR_LAT_US 40
`define FSR_LAT_CYC ((`FSR_LAT_US * `FSR_CLK_MHZ))
// Interval field: count 4'b0001, so (1+1)*64 = 128 us.
`define FSR_INT_COUNT 4'h1
`define FSR_INT_US 128
`define FSR_INT_CYC ((`FSR_INT_US * `FSR_CLK_MHZ))
`define FSR_RSVD_BIT 1'h1
`define FSR_PROHIB_ERS 4'hc
`define FSR_PROHIB_PGM 4'hc
`define FSR_DW12 32'h441883cc
`define FSR_DW13 32'h757a757a
// Register byte offsets on the bus.
`define FSR_REG_CMD 32'h00
`define FSR_REG_STAT 32'h04
`define FSR_REG_DW12 32'h08
`define FSR_REG_DW13 32'h0c
`define FSR_REG_TIMER 32'h10
`define FSR_STAT_W 8

`endif

//--- core/fsr_pkg.sv
/*
 * Types of the suspend and resume sequencer.
 * Assumes fsr_cfg.svh is compiled with it.
 */
package fsr_pkg;
    typedef enum logic [5:0] {
        FSR_IDLE = 6'h01,
        FSR_ERASE = 6'h02,
        FSR_PROGRAM = 6'h04,
        FSR_E_HALT = 6'h08,
        FSR_P_HALT = 6'h10,
        FSR_SUSP = 6'h20
    } fsr_state_t;

    typedef struct packed {
        logic [1:0] trans;
        logic write;
        logic [31:0] addr;
    } fsr_ahb_req_t;

    typedef struct packed {
        fsr_state_t st;
        logic susp_erase;
        logic [15:0] lat_cnt;
        logic [15:0] int_cnt;
        logic dphase;
        logic dwrite;
        logic [31:0] daddr;
        logic [31:0] rdata;
        logic [7:0] last_op;
        logic ignored;
    } fsr_regs_t;
endpackage : fsr_pkg

//--- core/fsr_seq.sv
/*
 * Suspend and resume sequencer of a serial flash, reached over AHB-Lite.
 * Software writes one-byte instruction codes to the command register;
 * the block tracks an erase or program, its suspension and resumption,
 * and exposes the discovery table words. Assumes a single-master bus.
 */
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "fsr_cfg.svh"

module fsr_seq
    import fsr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic o_busy,
    output logic o_suspended
);

    // ********************************************************
    // Constants
    // ********************************************************
    localparam logic [15:0] LAT_CYC = 16'(`FSR_LAT_CYC);
    localparam logic [15:0] INT_CYC = 16'(`FSR_INT_CYC);

    fsr_regs_t r;
    fsr_regs_t next_r;
    fsr_ahb_req_t req;

    function automatic logic [31:0] read_mux(input logic [31:0] a, input fsr_regs_t s);
        logic [31:0] v;
        v = 32'h0;
        unique case (a[7:0])
            8'(`FSR_REG_CMD): v = {24'h0, s.last_op};
            8'(`FSR_REG_STAT): v = {26'h0, s.ignored, s.susp_erase,
                                   (s.st == FSR_SUSP), (s.st != FSR_IDLE && s.st != FSR_SUSP),
                                   (s.int_cnt != 16'h0), (s.st == FSR_E_HALT || s.st == FSR_P_HALT)};
            8'(`FSR_REG_DW12): v = {1'b0, `FSR_LAT_UNIT, `FSR_LAT_COUNT, `FSR_INT_COUNT,
                                   `FSR_LAT_UNIT, `FSR_LAT_COUNT, `FSR_INT_COUNT,
                                   `FSR_RSVD_BIT, `FSR_PROHIB_ERS, `FSR_PROHIB_PGM};
            8'(`FSR_REG_DW13): v = `FSR_DW13;
            8'(`FSR_REG_TIMER): v = {s.lat_cnt, s.int_cnt};
            default: v = 32'h0;
        endcase
        return v;
    endfunction : read_mux

    // ********************************************************
    // Bus and sequencer
    // ********************************************************
    logic cmd_wr;
    logic [7:0] op;

    always_comb begin
        req = '{trans: i_htrans, write: i_hwrite, addr: i_haddr};
        next_r = r;
        cmd_wr = r.dphase && r.dwrite && (r.daddr[7:0] == 8'(`FSR_REG_CMD));
        op = i_hwdata[7:0];
        next_r.dphase = i_hsel && i_hready && req.trans[1];
        next_r.dwrite = req.write;
        next_r.daddr = req.addr;
        if (i_hsel && i_hready && req.trans[1] && !req.write) begin
            next_r.rdata = read_mux(req.addr, r);
        end
        if (r.lat_cnt != 16'h0) begin
            next_r.lat_cnt = r.lat_cnt - 16'h1;
        end
        if (r.int_cnt != 16'h0) begin
            next_r.int_cnt = r.int_cnt - 16'h1;
        end
        unique case (r.st)
            // erase halt completes when latency counter ends
            FSR_E_HALT: if (r.lat_cnt == 16'h1) begin
                next_r.st = FSR_SUSP;
            end
            // program halt completes the same way
            FSR_P_HALT: if (r.lat_cnt == 16'h1) begin
                next_r.st = FSR_SUSP;
            end
            default: ;
        endcase
        if (cmd_wr) begin
            next_r.last_op = op;
            next_r.ignored = 1'b0;
            unique case (r.st)
                FSR_IDLE: begin
                    if (op == `FSR_OP_ERASE) begin
                        next_r.st = FSR_ERASE;
                    end else if (op == `FSR_OP_PROGRAM) begin
                        next_r.st = FSR_PROGRAM;
                    end else if (op == `FSR_OP_RESUME) begin
                        // resume with nothing suspended is dropped
                        next_r.ignored = 1'b1;
                    end
                end
                FSR_ERASE: if (op == `FSR_OP_SUSPEND) begin
                    next_r.st = FSR_E_HALT;
                    next_r.susp_erase = 1'b1;
                    next_r.lat_cnt = LAT_CYC;
                end
                FSR_PROGRAM: if (op == `FSR_OP_SUSPEND) begin
                    next_r.st = FSR_P_HALT;
                    next_r.susp_erase = 1'b0;
                    next_r.lat_cnt = LAT_CYC;
                end
                FSR_SUSP: if (op == `FSR_OP_RESUME) begin
                    // interval timer shows when re-suspend is allowed
                    next_r.st = r.susp_erase ? FSR_ERASE : FSR_PROGRAM;
                    next_r.int_cnt = INT_CYC;
                end
                default: ;
            endcase
        end
        // The array completing its operation is modelled by a write of
        // zero to the command register; no array timing lives here.
        if (cmd_wr && op == 8'h00 && (r.st == FSR_ERASE || r.st == FSR_PROGRAM)) begin
            next_r.st = FSR_IDLE;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            r <= '{st: FSR_IDLE, default: '0};
        end else begin
            r <= next_r;
        end
    end

    assign o_hrdata = r.rdata;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_busy = (r.st != FSR_IDLE) && (r.st != FSR_SUSP);
    assign o_suspended = (r.st == FSR_SUSP);

    // ********************************************************
    // Checks
    // ********************************************************
    // The discovery word as software would read it, for the field checks below.
    logic [31:0] dw12_view;

    assign dw12_view = read_mux(`FSR_REG_DW12, r);

    // The latency counter is the helper count of a halt: it starts at no more than
    // 40 us (10000 cycles at 250 MHz), falls by one each cycle, and a halt may never
    // outlive it, so no halt lasts longer than the bound.
    a_erase_halt_bound: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        r.st == FSR_E_HALT |-> r.lat_cnt != 16'h0 && r.lat_cnt <= 16'h2710)
        else $error("erase suspend latency exceeded");
    a_prog_halt_bound: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        r.st == FSR_P_HALT |-> r.lat_cnt != 16'h0 && r.lat_cnt <= 16'h2710)
        else $error("program suspend latency exceeded");
    a_halt_release: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        (r.st == FSR_E_HALT || r.st == FSR_P_HALT) && r.lat_cnt == 16'h1 |=> o_suspended)
        else $error("halt did not end in suspension");
    a_resume_interval: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        r.st == FSR_SUSP && cmd_wr && op == `FSR_OP_RESUME |=> r.int_cnt == INT_CYC)
        else $error("resume interval not started");
    a_resume_target: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        r.st == FSR_SUSP && cmd_wr && op == `FSR_OP_RESUME && !r.susp_erase
        |=> r.st == FSR_PROGRAM)
        else $error("program resume went wrong");
    a_erase_resume: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        r.st == FSR_SUSP && cmd_wr && op == `FSR_OP_RESUME && r.susp_erase
        |=> r.st == FSR_ERASE)
        else $error("erase resume went wrong");
    a_idle_resume: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        r.st == FSR_IDLE && cmd_wr && op == `FSR_OP_RESUME |=> r.st == FSR_IDLE && r.ignored)
        else $error("idle resume changed state");
    a_dword_value: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        dw12_view == `FSR_DW12 && dw12_view[8] == 1'b1)
        else $error("discovery dword wrong");
    a_support_flag: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        dw12_view[31] == 1'b0)
        else $error("support flag not zero");
    a_halt_busy: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        r.st == FSR_E_HALT |-> o_busy && !o_suspended)
        else $error("halting but not busy");
    a_lat_field: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        dw12_view[30:24] == 7'h44 && dw12_view[19:13] == 7'h44)
        else $error("latency field wrong");
    a_int_field: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        dw12_view[23:20] == 4'h1 && dw12_view[12:9] == 4'h1)
        else $error("interval field wrong");

endmodule : fsr_seq

//--- tb/fsr_host.sv
/* Host model: an AHB-Lite master doing single word transfers.
   Assumes the one slave's hreadyout is looped back as hready. */
`timescale 1ns/1ps
module fsr_host (
    input wire logic i_clk,
    input wire logic i_hready,
    input wire logic [31:0] i_hrdata,
    output logic o_hsel,
    output logic [31:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [2:0] o_hsize,
    output logic [31:0] o_hwdata
);
    initial begin
        o_hsel = 1'h0;
        o_haddr = 32'h0;
        o_htrans = 2'h0;
        o_hwrite = 1'h0;
        o_hsize = 3'h2;
        o_hwdata = 32'h0;
    end
    // The address phase is held until hready is seen, so a waited slave also works.
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge i_clk);
        o_hsel <= 1'h1;
        o_htrans <= 2'h2;
        o_haddr <= a;
        o_hwrite <= wr;
        do @(posedge i_clk); while (i_hready !== 1'h1);
        o_htrans <= 2'h0;
        o_hwdata <= d;
        do @(posedge i_clk); while (i_hready !== 1'h1);
        q = i_hrdata;
    endtask : xfer
endmodule : fsr_host

//--- tb/fsr_tb.sv
/* Self-checking bench of the suspend and resume sequencer.
   Assumes the sequencer answers OKAY with zero wait states. */
`timescale 1ns/1ps
module testbench;
    import fsr_pkg::*;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic hsel, hwrite, hready, hresp, busy, susp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, q;
    int num_errors = 0;
    int n_checks = 0;
    always #2 clk = ~clk;
    fsr_host i_fsr_host (.i_clk(clk), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
        .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
        .o_hwdata(hwdata));
    fsr_seq i_fsr_seq (.i_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .o_busy(busy), .o_suspended(susp));
    task automatic finish_test();
        if (num_errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic get(input logic [31:0] a);
        i_fsr_host.xfer(1'h0, a, 32'h0, q);
        chk({31'h0, hresp}, 32'h0);
    endtask : get
    task automatic cmd(input logic [7:0] c);
        i_fsr_host.xfer(1'h1, 32'h0, {24'h0, c}, q);
        #1;
    endtask : cmd
    task automatic st(input logic b, input logic s);
        chk({30'h0, busy, susp}, {30'h0, b, s});
    endtask : st
    // A suspend must land within 40 us, which is 10000 cycles at 250 MHz.
    task automatic lat();
        int n;
        n = 0;
        while (susp !== 1'h1 && n < 20000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({31'h0, n <= 10000}, 32'h1);
    endtask : lat
    initial begin
        #400000;
        num_errors++;
        finish_test();
    end
    /***********************************
     * Main sequence
     ***********************************/
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        #1;
        st(1'h0, 1'h0);
        get(32'h08);
        chk(q, 32'h441883cc);
        chk({31'h0, q[31]}, 32'h0);
        chk({25'h0, q[30:24]}, {25'h0, 2'b10, 5'b00100});
        chk({28'h0, q[23:20]}, 32'h1);
        chk({25'h0, q[19:13]}, {25'h0, 2'b10, 5'b00100});
        chk({28'h0, q[12:9]}, 32'h1);
        chk({31'h0, q[8]}, 32'h1);
        get(32'h0c);
        chk(q, 32'h757a757a);
        get(32'h40);
        chk(q, 32'h0);
        i_fsr_host.xfer(1'h1, 32'h08, 32'h0, q);
        get(32'h08);
        chk(q, 32'h441883cc);
        cmd(8'h7a);
        st(1'h0, 1'h0);
        get(32'h04);
        chk({31'h0, q[5]}, 32'h1);
        cmd(8'h20);
        st(1'h1, 1'h0);
        cmd(8'h75);
        lat();
        st(1'h0, 1'h1);
        get(32'h04);
        chk({30'h0, q[4:3]}, 32'h3);
        // Only the status is read while suspended; the erase is then resumed.
        cmd(8'h7a);
        st(1'h1, 1'h0);
        // The interval of 128 us is 32000 cycles; it still runs just before its end.
        repeat (31990) @(posedge clk);
        get(32'h04);
        chk({31'h0, q[1]}, 32'h1);
        repeat (8) @(posedge clk);
        get(32'h04);
        chk({31'h0, q[1]}, 32'h0);
        cmd(8'h75);
        lat();
        cmd(8'h7a);
        cmd(8'h00);
        st(1'h0, 1'h0);
        cmd(8'h02);
        st(1'h1, 1'h0);
        cmd(8'h75);
        lat();
        get(32'h04);
        chk({30'h0, q[4:3]}, 32'h1);
        cmd(8'h7a);
        st(1'h1, 1'h0);
        // The program is ended, never suspended again within the interval.
        cmd(8'h00);
        st(1'h0, 1'h0);
        finish_test();
    end
endmodule : testbench
